// file: gpio_six_eight_pkg.sv
package gpio_six_eight_pkg;

    localparam int PORT_WIDTH = 8;
    localparam int PORT_COUNT = 3;

    // Bits that physically exist on each port
    localparam logic [7:0] PORT_SIX_EXISTS = 8'hff;
    localparam logic [7:0] PORT_SEVEN_EXISTS = 8'hdf;
    localparam logic [7:0] PORT_EIGHT_EXISTS = 8'hdf;

    // Bits whose secondary output is a constant zero
    localparam logic [7:0] PORT_SIX_ALT_ZERO = 8'h5f;
    localparam logic [7:0] PORT_SEVEN_ALT_ZERO = 8'h00;
    localparam logic [7:0] PORT_EIGHT_ALT_ZERO = 8'h01;

    // Value after any reset cause for data, direction and select
    localparam logic [7:0] PORT_RESET_VALUE = 8'h00;

    // Bit positions of the secondary functions
    localparam int SIX_IRQ_A_BIT = 0;
    localparam int SIX_IRQ_B_BIT = 1;
    localparam int SIX_IRQ_C_BIT = 2;
    localparam int SIX_IRQ_D_BIT = 3;
    localparam int SIX_TIMER_EVT_BIT = 4;
    localparam int SIX_TIMER_ONE_BIT = 5;
    localparam int SIX_TIMER_TWO_BIT = 7;
    localparam int SEVEN_PWM_A_BIT = 6;
    localparam int SEVEN_PWM_B_BIT = 7;
    localparam int EIGHT_SERIAL_RX_BIT = 0;

endpackage

// file: gpio_pin_cell.sv
`timescale 1ns/1ps

module gpio_pin_cell #(
    parameter bit EXISTS = 1'b1,
    parameter bit ALT_ZERO = 1'b0
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic data_i,
    input wire logic dir_i,
    input wire logic sel_i,
    input wire logic alt_out_i,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_o,
    output logic pullup_o,
    output logic level_o,
    output logic read_o
);

    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic level_q;
    logic drive_d;

    ////////////////////////////////////////////////////////////////////////
    // Pin input: three stages, accepted once the last two agree
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            level_q <= 1'b0;
        end else if (EXISTS && (sync2_q == sync3_q)) begin
            level_q <= sync2_q;
        end
    end

    assign level_o = level_q;

    ////////////////////////////////////////////////////////////////////////
    // Output drive and read-back
    always_comb begin
        drive_d = data_i;
        if (sel_i) begin
            drive_d = ALT_ZERO ? 1'b0 : alt_out_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0;
            pullup_o <= 1'b0;
        end else begin
            pin_o <= EXISTS & dir_i & drive_d;
            pin_oe_o <= EXISTS & dir_i;
            pullup_o <= EXISTS & ~dir_i & sel_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            read_o <= 1'b0;
        end else if (!EXISTS) begin
            read_o <= 1'b0;
        end else begin
            read_o <= dir_i ? drive_d : level_q;
        end
    end

endmodule // gpio_pin_cell

// file: gpio_ports_six_to_eight.sv
`timescale 1ns/1ps


module gpio_ports_six_to_eight
    import gpio_six_eight_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] port_six_wdata_i,
    input wire logic port_six_data_we_i,
    input wire logic port_six_direction_we_i,
    input wire logic port_six_alt_select_we_i,
    input wire logic [7:0] port_seven_wdata_i,
    input wire logic port_seven_data_we_i,
    input wire logic port_seven_direction_we_i,
    input wire logic port_seven_alt_select_we_i,
    input wire logic [7:0] port_eight_wdata_i,
    input wire logic port_eight_data_we_i,
    input wire logic port_eight_direction_we_i,
    input wire logic port_eight_alt_select_we_i,
    input wire logic timer_one_out_i,
    input wire logic timer_two_out_i,
    input wire logic pwm_ch_a_out_i,
    input wire logic pwm_ch_b_out_i,
    input wire logic [7:0] port_eight_alt_out_i,
    input wire logic [7:0] port_six_pin_i,
    input wire logic [7:0] port_seven_pin_i,
    input wire logic [7:0] port_eight_pin_i,
    output logic [7:0] port_six_pin_o,
    output logic [7:0] port_six_pin_oe_o,
    output logic [7:0] port_six_pullup_o,
    output logic [7:0] port_seven_pin_o,
    output logic [7:0] port_seven_pin_oe_o,
    output logic [7:0] port_seven_pullup_o,
    output logic [7:0] port_eight_pin_o,
    output logic [7:0] port_eight_pin_oe_o,
    output logic [7:0] port_eight_pullup_o,
    output logic [7:0] port_six_data_o,
    output logic [7:0] port_six_direction_o,
    output logic [7:0] port_six_alt_select_o,
    output logic [7:0] port_seven_data_o,
    output logic [7:0] port_seven_direction_o,
    output logic [7:0] port_seven_alt_select_o,
    output logic [7:0] port_eight_data_o,
    output logic [7:0] port_eight_direction_o,
    output logic [7:0] port_eight_alt_select_o,
    output logic [7:0] port_six_read_o,
    output logic [7:0] port_seven_read_o,
    output logic [7:0] port_eight_read_o,
    output logic ext_irq_in_a_o,
    output logic ext_irq_in_b_o,
    output logic ext_irq_in_c_o,
    output logic ext_irq_in_d_o,
    output logic timer_one_event_in_o,
    output logic serial_chan_one_rxd_o
);

    localparam int ALL_BITS = PORT_WIDTH * PORT_COUNT;
    localparam logic [ALL_BITS-1:0] EXISTS_ALL =
        {PORT_EIGHT_EXISTS, PORT_SEVEN_EXISTS, PORT_SIX_EXISTS};
    localparam logic [ALL_BITS-1:0] ALT_ZERO_ALL =
        {PORT_EIGHT_ALT_ZERO, PORT_SEVEN_ALT_ZERO, PORT_SIX_ALT_ZERO};

    logic [7:0] wdata [PORT_COUNT];
    logic [PORT_COUNT-1:0] data_we;
    logic [PORT_COUNT-1:0] dir_we;
    logic [PORT_COUNT-1:0] sel_we;
    logic [7:0] data_q [PORT_COUNT];
    logic [7:0] dir_q [PORT_COUNT];
    logic [7:0] sel_q [PORT_COUNT];
    logic [7:0] mask [PORT_COUNT];

    logic [ALL_BITS-1:0] data_all;
    logic [ALL_BITS-1:0] dir_all;
    logic [ALL_BITS-1:0] sel_all;
    logic [ALL_BITS-1:0] alt_all;
    logic [ALL_BITS-1:0] pin_in_all;
    logic [ALL_BITS-1:0] pin_out_all;
    logic [ALL_BITS-1:0] pin_oe_all;
    logic [ALL_BITS-1:0] pullup_all;
    logic [ALL_BITS-1:0] level_all;
    logic [ALL_BITS-1:0] read_all;
    logic [7:0] six_alt;
    logic [7:0] seven_alt;

    ////////////////////////////////////////////////////////////////////////
    // Software write side
    assign wdata[0] = port_six_wdata_i;
    assign wdata[1] = port_seven_wdata_i;
    assign wdata[2] = port_eight_wdata_i;
    assign data_we = {port_eight_data_we_i, port_seven_data_we_i, port_six_data_we_i};
    assign dir_we = {port_eight_direction_we_i, port_seven_direction_we_i,
                     port_six_direction_we_i};
    assign sel_we = {port_eight_alt_select_we_i, port_seven_alt_select_we_i,
                     port_six_alt_select_we_i};
    assign mask[0] = PORT_SIX_EXISTS;
    assign mask[1] = PORT_SEVEN_EXISTS;
    assign mask[2] = PORT_EIGHT_EXISTS;

    // Missing bits never store anything, so they read back as zero
    for (genvar p = 0; p < PORT_COUNT; p++) begin : g_regs
        always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                data_q[p] <= PORT_RESET_VALUE;
            end else if (data_we[p]) begin
                data_q[p] <= wdata[p] & mask[p];
            end
        end

        always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                dir_q[p] <= PORT_RESET_VALUE;
            end else if (dir_we[p]) begin
                dir_q[p] <= wdata[p] & mask[p];
            end
        end

        always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
                sel_q[p] <= PORT_RESET_VALUE;
            end else if (sel_we[p]) begin
                sel_q[p] <= wdata[p] & mask[p];
            end
        end

        assign data_all[p*PORT_WIDTH +: PORT_WIDTH] = data_q[p];
        assign dir_all[p*PORT_WIDTH +: PORT_WIDTH] = dir_q[p];
        assign sel_all[p*PORT_WIDTH +: PORT_WIDTH] = sel_q[p];
    end

    assign port_six_data_o = data_q[0];
    assign port_six_direction_o = dir_q[0];
    assign port_six_alt_select_o = sel_q[0];
    assign port_seven_data_o = data_q[1];
    assign port_seven_direction_o = dir_q[1];
    assign port_seven_alt_select_o = sel_q[1];
    assign port_eight_data_o = data_q[2];
    assign port_eight_direction_o = dir_q[2];
    assign port_eight_alt_select_o = sel_q[2];

    ////////////////////////////////////////////////////////////////////////
    // Peripheral outputs onto secondary bits
    always_comb begin
        six_alt = 8'h00;
        six_alt[SIX_TIMER_ONE_BIT] = timer_one_out_i;
        six_alt[SIX_TIMER_TWO_BIT] = timer_two_out_i;
    end

    always_comb begin
        seven_alt = 8'h00;
        seven_alt[SEVEN_PWM_A_BIT] = pwm_ch_a_out_i;
        seven_alt[SEVEN_PWM_B_BIT] = pwm_ch_b_out_i;
    end

    assign alt_all = {port_eight_alt_out_i, seven_alt, six_alt};
    assign pin_in_all = {port_eight_pin_i, port_seven_pin_i, port_six_pin_i};

    ////////////////////////////////////////////////////////////////////////
    // Pin cells
    for (genvar b = 0; b < ALL_BITS; b++) begin : g_cell
        gpio_pin_cell #(
            .EXISTS(EXISTS_ALL[b]),
            .ALT_ZERO(ALT_ZERO_ALL[b])
        ) u_cell (
            .sys_clk_i(sys_clk_i),
            .sys_rst_i(sys_rst_i),
            .data_i(data_all[b]),
            .dir_i(dir_all[b]),
            .sel_i(sel_all[b]),
            .alt_out_i(alt_all[b]),
            .pin_i(pin_in_all[b]),
            .pin_o(pin_out_all[b]),
            .pin_oe_o(pin_oe_all[b]),
            .pullup_o(pullup_all[b]),
            .level_o(level_all[b]),
            .read_o(read_all[b])
        );
    end

    assign port_six_pin_o = pin_out_all[7:0];
    assign port_six_pin_oe_o = pin_oe_all[7:0];
    assign port_six_pullup_o = pullup_all[7:0];
    assign port_seven_pin_o = pin_out_all[15:8];
    assign port_seven_pin_oe_o = pin_oe_all[15:8];
    assign port_seven_pullup_o = pullup_all[15:8];
    assign port_eight_pin_o = pin_out_all[23:16];
    assign port_eight_pin_oe_o = pin_oe_all[23:16];
    assign port_eight_pullup_o = pullup_all[23:16];
    assign port_six_read_o = read_all[7:0];
    assign port_seven_read_o = read_all[15:8];
    assign port_eight_read_o = read_all[23:16];

    ////////////////////////////////////////////////////////////////////////
    // Secondary inputs share the filtered pin level with the port read
    assign ext_irq_in_a_o = level_all[SIX_IRQ_A_BIT];
    assign ext_irq_in_b_o = level_all[SIX_IRQ_B_BIT];
    assign ext_irq_in_c_o = level_all[SIX_IRQ_C_BIT];
    assign ext_irq_in_d_o = level_all[SIX_IRQ_D_BIT];
    assign timer_one_event_in_o = level_all[SIX_TIMER_EVT_BIT];
    assign serial_chan_one_rxd_o = level_all[2*PORT_WIDTH + EIGHT_SERIAL_RX_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_six_oe_dir: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> port_six_pin_oe_o == $past(dir_q[0]))
        else $error("port six enable does not follow direction");

    a_seven_data_drive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> ((port_seven_pin_o ^ $past(data_q[1])) & $past(dir_q[1] & ~sel_q[1])) == 8'h00)
        else $error("port seven output does not drive data");

    a_eight_data_drive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> ((port_eight_pin_o ^ $past(data_q[2])) & $past(dir_q[2] & ~sel_q[2])) == 8'h00)
        else $error("port eight output does not drive data");

    a_six_timer_drive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        dir_q[0][SIX_TIMER_ONE_BIT] && sel_q[0][SIX_TIMER_ONE_BIT]
        |=> port_six_pin_o[SIX_TIMER_ONE_BIT] == $past(timer_one_out_i)
            && port_six_read_o[SIX_TIMER_ONE_BIT] == $past(timer_one_out_i))
        else $error("timer one output not on port six pin");

    a_irq_pin_level: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        port_six_pin_i[SIX_IRQ_A_BIT] [*5] |=> ext_irq_in_a_o)
        else $error("interrupt input does not follow steady pin");

    a_pullup_input: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> port_eight_pullup_o == ($past(~dir_q[2] & sel_q[2]) & PORT_EIGHT_EXISTS))
        else $error("port eight pull-up wrong");

    a_six_alt_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> ((port_six_pin_o | port_six_read_o)
                  & $past(dir_q[0] & sel_q[0]) & PORT_SIX_ALT_ZERO) == 8'h00)
        else $error("port six fixed-zero secondary bit not zero");

    a_eight_alt_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        dir_q[2][0] && sel_q[2][0] |=> !port_eight_pin_o[0])
        else $error("port eight bit zero secondary output not zero");

    a_reset_undriven: assert property (@(posedge sys_clk_i)
        sys_rst_i |-> (port_six_pin_oe_o | port_seven_pin_oe_o | port_eight_pin_oe_o) == 8'h00
            && (data_q[0] | data_q[1] | data_q[2] | dir_q[0] | dir_q[1] | dir_q[2]
                | sel_q[0] | sel_q[1] | sel_q[2]) == 8'h00)
        else $error("port not cleared under reset");

    a_read_select: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> ((port_six_read_o ^ $past(data_q[0])) & $past(dir_q[0] & ~sel_q[0])) == 8'h00)
        else $error("port six output read does not return data");

    a_missing_bit_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ((port_seven_read_o | port_seven_direction_o | port_eight_data_o)
         & ~PORT_SEVEN_EXISTS) == 8'h00)
        else $error("nonexistent bit reads one");

    a_pull_off_out: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (port_six_pin_oe_o & port_six_pullup_o) == 8'h00
        && (port_seven_pin_oe_o & port_seven_pullup_o) == 8'h00)
        else $error("pull-up on while driving");

    a_six_data_drive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> ((port_six_pin_o ^ $past(data_q[0])) & $past(dir_q[0] & ~sel_q[0])) == 8'h00)
        else $error("port six output does not drive data");

    a_seven_oe_dir: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> port_seven_pin_oe_o == $past(dir_q[1]))
        else $error("port seven enable does not follow direction");

    a_eight_oe_dir: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> port_eight_pin_oe_o == $past(dir_q[2]))
        else $error("port eight enable does not follow direction");

    a_eight_alt_drive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> ((port_eight_pin_o ^ $past(port_eight_alt_out_i)) & $past(dir_q[2] & sel_q[2])
                  & PORT_EIGHT_EXISTS & ~PORT_EIGHT_ALT_ZERO) == 8'h00)
        else $error("port eight secondary output wrong");

    a_irq_pin_low: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (!port_six_pin_i[SIX_IRQ_A_BIT]) [*5] |=> !ext_irq_in_a_o)
        else $error("interrupt input does not follow low pin");

    a_six_pull_input: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> port_six_pullup_o == $past(~dir_q[0] & sel_q[0]))
        else $error("port six pull-up wrong");

    a_seven_pull_input: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> port_seven_pullup_o == ($past(~dir_q[1] & sel_q[1]) & PORT_SEVEN_EXISTS))
        else $error("port seven pull-up wrong");

    a_input_read_pin: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        1'b1 |=> ((port_eight_read_o ^ $past(level_all[23:16])) & $past(~dir_q[2])
                  & PORT_EIGHT_EXISTS) == 8'h00)
        else $error("port eight input read does not return pin");

    a_pwm_a_drive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        dir_q[1][SEVEN_PWM_A_BIT] && sel_q[1][SEVEN_PWM_A_BIT]
        |=> port_seven_pin_o[SEVEN_PWM_A_BIT] == $past(pwm_ch_a_out_i)
            && port_seven_read_o[SEVEN_PWM_A_BIT] == $past(pwm_ch_a_out_i))
        else $error("first pwm output not on port seven");

    a_pwm_b_drive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        dir_q[1][SEVEN_PWM_B_BIT] && sel_q[1][SEVEN_PWM_B_BIT]
        |=> port_seven_pin_o[SEVEN_PWM_B_BIT] == $past(pwm_ch_b_out_i)
            && port_seven_read_o[SEVEN_PWM_B_BIT] == $past(pwm_ch_b_out_i))
        else $error("second pwm output not on port seven");

    a_rmw_write_back: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        port_six_data_we_i |=> port_six_data_o == ($past(port_six_wdata_i) & PORT_SIX_EXISTS))
        else $error("port six write not stored");

    a_evt_pin_level: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        port_six_pin_i[SIX_TIMER_EVT_BIT] [*5] |=> timer_one_event_in_o)
        else $error("timer event input does not follow steady pin");

    a_rxd_pin_high: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        port_eight_pin_i[EIGHT_SERIAL_RX_BIT] [*5] |=> serial_chan_one_rxd_o)
        else $error("serial receive input does not follow high pin");

    a_rxd_pin_low: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (!port_eight_pin_i[EIGHT_SERIAL_RX_BIT]) [*5] |=> !serial_chan_one_rxd_o)
        else $error("serial receive input does not follow low pin");

    a_eight_missing_zero: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ((port_eight_read_o | port_eight_direction_o | port_eight_alt_select_o)
         & ~PORT_EIGHT_EXISTS) == 8'h00)
        else $error("port eight nonexistent bit reads one");

endmodule // gpio_ports_six_to_eight

// file: gpio_board_model.sv
`timescale 1ns/1ps

// Board side of one port: resolves each pin from the device drive, an external
// driver and the pull-up; an undriven, unpulled pin wanders every cycle
module gpio_board_model (
    input wire logic sys_clk_i,
    input wire logic [7:0] pin_o_i,
    input wire logic [7:0] pin_oe_i,
    input wire logic [7:0] pullup_i,
    input wire logic [7:0] ext_drive_i,
    input wire logic [7:0] ext_level_i,
    output logic [7:0] pin_level_o
);
    logic [7:0] float_q;

    initial float_q = 8'h55;

    always @(posedge sys_clk_i) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe_i[i]) begin
                pin_level_o[i] = pin_o_i[i];
            end else if (ext_drive_i[i]) begin
                pin_level_o[i] = ext_level_i[i];
            end else if (pullup_i[i]) begin
                pin_level_o[i] = 1'b1;
            end else begin
                pin_level_o[i] = float_q[i];
            end
        end
    end
endmodule // gpio_board_model

// file: testbench.sv
`timescale 1ns/1ps

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end

module testbench
    import gpio_six_eight_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b0;
    logic [7:0] wdata [3];
    logic we_d [3];
    logic we_r [3];
    logic we_s [3];
    logic [7:0] pin_i [3];
    logic [7:0] pin_o [3];
    logic [7:0] oe [3];
    logic [7:0] pu [3];
    logic [7:0] dat [3];
    logic [7:0] dir [3];
    logic [7:0] sel [3];
    logic [7:0] rd [3];
    logic [7:0] ext_drv [3];
    logic [7:0] ext_lvl [3];
    logic t1 = 1'b0;
    logic t2 = 1'b0;
    logic pa = 1'b0;
    logic pb = 1'b0;
    logic [7:0] alt8 = 8'h00;
    logic irq_a, irq_b, irq_c, irq_d, tm_evt, rxd;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [7:0] exist [3];

    initial begin
        exist = '{PORT_SIX_EXISTS, PORT_SEVEN_EXISTS, PORT_EIGHT_EXISTS};
        for (int p = 0; p < 3; p++) begin
            wdata[p] <= 8'h00;
            we_d[p] <= 1'b0;
            we_r[p] <= 1'b0;
            we_s[p] <= 1'b0;
            ext_drv[p] <= 8'h00;
            ext_lvl[p] <= 8'h00;
        end
    end

    always #2.5 sys_clk = ~sys_clk;

    gpio_ports_six_to_eight u_gpio_ports_six_to_eight (
        .sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
        .port_six_wdata_i(wdata[0]), .port_six_data_we_i(we_d[0]),
        .port_six_direction_we_i(we_r[0]), .port_six_alt_select_we_i(we_s[0]),
        .port_seven_wdata_i(wdata[1]), .port_seven_data_we_i(we_d[1]),
        .port_seven_direction_we_i(we_r[1]), .port_seven_alt_select_we_i(we_s[1]),
        .port_eight_wdata_i(wdata[2]), .port_eight_data_we_i(we_d[2]),
        .port_eight_direction_we_i(we_r[2]), .port_eight_alt_select_we_i(we_s[2]),
        .timer_one_out_i(t1), .timer_two_out_i(t2),
        .pwm_ch_a_out_i(pa), .pwm_ch_b_out_i(pb), .port_eight_alt_out_i(alt8),
        .port_six_pin_i(pin_i[0]), .port_seven_pin_i(pin_i[1]), .port_eight_pin_i(pin_i[2]),
        .port_six_pin_o(pin_o[0]), .port_six_pin_oe_o(oe[0]), .port_six_pullup_o(pu[0]),
        .port_seven_pin_o(pin_o[1]), .port_seven_pin_oe_o(oe[1]), .port_seven_pullup_o(pu[1]),
        .port_eight_pin_o(pin_o[2]), .port_eight_pin_oe_o(oe[2]), .port_eight_pullup_o(pu[2]),
        .port_six_data_o(dat[0]), .port_six_direction_o(dir[0]),
        .port_six_alt_select_o(sel[0]),
        .port_seven_data_o(dat[1]), .port_seven_direction_o(dir[1]),
        .port_seven_alt_select_o(sel[1]),
        .port_eight_data_o(dat[2]), .port_eight_direction_o(dir[2]),
        .port_eight_alt_select_o(sel[2]),
        .port_six_read_o(rd[0]), .port_seven_read_o(rd[1]), .port_eight_read_o(rd[2]),
        .ext_irq_in_a_o(irq_a), .ext_irq_in_b_o(irq_b), .ext_irq_in_c_o(irq_c),
        .ext_irq_in_d_o(irq_d), .timer_one_event_in_o(tm_evt), .serial_chan_one_rxd_o(rxd)
    );

    for (genvar g = 0; g < 3; g++) begin : g_board
        gpio_board_model u_gpio_board_model (
            .sys_clk_i(sys_clk), .pin_o_i(pin_o[g]), .pin_oe_i(oe[g]), .pullup_i(pu[g]),
            .ext_drive_i(ext_drv[g]), .ext_level_i(ext_lvl[g]), .pin_level_o(pin_i[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_sim();
        end
    end

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // Kind 0 data, 1 direction, 2 select
    task automatic wr(input int p, input int k, input logic [7:0] v);
        @(posedge sys_clk);
        wdata[p] <= v;
        if (k == 0) we_d[p] <= 1'b1;
        if (k == 1) we_r[p] <= 1'b1;
        if (k == 2) we_s[p] <= 1'b1;
        @(posedge sys_clk);
        we_d[p] <= 1'b0;
        we_r[p] <= 1'b0;
        we_s[p] <= 1'b0;
    endtask

    task automatic cfg(input int p, input logic [7:0] d, input logic [7:0] r,
                       input logic [7:0] s);
        wr(p, 0, d);
        wr(p, 1, r);
        wr(p, 2, s);
        settle(3);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        for (int p = 0; p < 3; p++) cfg(p, 8'hff, 8'hff, 8'hff);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        settle(2);
        for (int p = 0; p < 3; p++) begin
            `CHK({dat[p], dir[p], sel[p]}, {3{PORT_RESET_VALUE}})
            `CHK(oe[p], 8'h00)
        end
    endtask

    task automatic test_output();
        for (int p = 0; p < 3; p++) begin
            cfg(p, 8'ha5, 8'hff, 8'h00);
            `CHK(dat[p], 8'ha5 & exist[p])
            `CHK(oe[p], exist[p])
            `CHK(pin_o[p], 8'ha5 & exist[p])
            `CHK(rd[p], 8'ha5 & exist[p])
            `CHK(pu[p], 8'h00)
        end
    endtask

    task automatic test_alt_out();
        for (int p = 0; p < 3; p++) cfg(p, 8'hff, 8'hff, 8'hff);
        for (int v = 1; v >= 0; v--) begin
            @(posedge sys_clk);
            t1 <= v[0];
            t2 <= v[0];
            pa <= v[0];
            pb <= v[0];
            alt8 <= {8{v[0]}};
            settle(3);
            `CHK(pin_o[0], {v[0], 1'b0, v[0], 5'h00})
            `CHK(rd[0], {v[0], 1'b0, v[0], 5'h00})
            `CHK(pin_o[1], {v[0], v[0], 6'h00})
            `CHK(rd[1], {v[0], v[0], 6'h00})
            `CHK(pin_o[2], {8{v[0]}} & exist[2] & ~PORT_EIGHT_ALT_ZERO)
            `CHK(pu[2], 8'h00)
        end
    endtask

    task automatic test_input();
        logic [7:0] pat [3];
        pat = '{8'h96, 8'h3c, 8'h69};
        for (int p = 0; p < 3; p++) begin
            cfg(p, 8'hff, 8'h00, 8'hff);
            ext_drv[p] <= 8'hff;
            ext_lvl[p] <= pat[p];
        end
        settle(8);
        for (int p = 0; p < 3; p++) begin
            `CHK(oe[p], 8'h00)
            `CHK(pu[p], exist[p])
            `CHK(rd[p], pat[p] & exist[p])
        end
        `CHK({tm_evt, irq_d, irq_c, irq_b, irq_a}, pat[0][4:0])
        `CHK(rxd, pat[2][0])
        for (int p = 0; p < 3; p++) ext_drv[p] <= 8'h00;
        settle(8);
        for (int p = 0; p < 3; p++) begin
            `CHK(rd[p], exist[p])
        end
    endtask

    task automatic test_rmw();
        logic [7:0] v;
        ext_drv[0] <= 8'hf0;
        ext_lvl[0] <= 8'ha0;
        cfg(0, 8'h05, 8'h0f, 8'h00);
        settle(6);
        v = rd[0];
        `CHK(v, 8'ha5)
        wr(0, 0, v | 8'h02);
        settle(1);
        `CHK(dat[0], 8'ha7)
        ext_drv[0] <= 8'h00;
    endtask

    initial begin
        sys_rst <= 1'b1;
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        settle(2);
        for (int p = 0; p < 3; p++) begin
            `CHK(pin_o[p] | oe[p] | pu[p] | rd[p], 8'h00)
        end
        test_output();
        test_alt_out();
        test_input();
        test_rmw();
        test_reset();
        end_sim();
    end
endmodule // testbench
